// [hdl/audio_cfg_pkg.sv]
// constants and types of the audio serial configuration block
// How it works
// - reserved configuration bits ignore writes and read back as zero
// - receive threshold field is 4 bits; threshold is (field + 1) * 2
// - receive service flag set while receive level >= receive threshold
// - transmit threshold field is 4 bits; threshold is field * 2
// - transmit service flag set while transmit level <= transmit threshold
// - on underflow play zero when policy is 0, repeat last sample when 1
// - codec select 0 routes audio to external codec, 1 to internal
// - format select 0 runs AC-link, 1 runs I2S or MSB-justified
// - writing 1 to reset bit clears controller state except config, divider
// - I2S bit clock: direction 0 input, 1 driven out; AC-link always input
// - I2S sync: direction 0 input, 1 driven out; AC-link always output
// - enable bit 0 disables the controller, 1 enables it
// - I2S role: slave, master on external clock, reserved, or master
// - as I2S master the bit clock is 64 times the sample rate
// - while disabled pin directions still follow settings, outputs low
package audio_cfg_pkg;

  // ==========================================================
  // register map (byte offsets)
  localparam logic [5:0] OFS_CONFIG = 6'h00;
  localparam logic [5:0] OFS_FMT_CTRL = 6'h10;
  localparam logic [5:0] OFS_FIFO_STAT = 6'h14;
  localparam logic [5:0] OFS_CLK_DIV = 6'h30;

  // ==========================================================
  // configuration register layout
  localparam logic [31:0] CONFIG_RESET = 32'h00007800;
  localparam logic [31:0] CONFIG_WMASK = 32'h0000ff77;
  localparam int RX_TH_LSB = 12;
  localparam int TX_TH_LSB = 8;
  localparam int TH_W = 4;
  localparam int POLICY_BIT = 6;
  localparam int CODEC_BIT = 5;
  localparam int FORMAT_BIT = 4;
  localparam int RESET_BIT = 3;
  localparam int CLKDIR_BIT = 2;
  localparam int SYNCDIR_BIT = 1;
  localparam int ENABLE_BIT = 0;

  // ==========================================================
  // format control, divider and status layout
  localparam int STOP_BIT = 4;
  localparam logic [31:0] FMT_RESET = 32'h00000000;
  localparam logic [31:0] FMT_WMASK = 32'h00000010;
  localparam int DIV_W = 4;
  localparam logic [3:0] DIV_RESET = 4'h3;
  localparam int LEVEL_W = 6;
  localparam int STAT_RX_LVL_LSB = 24;
  localparam int STAT_TX_LVL_LSB = 8;
  localparam int STAT_RX_FLAG_BIT = 4;
  localparam int STAT_TX_FLAG_BIT = 3;

  // ==========================================================
  // framing
  localparam int SAMPLE_W = 24;
  localparam int BIT_CNT_W = 8;
  localparam int I2S_FRAME_BITS = 64;
  localparam int I2S_LR_BIT = $clog2(I2S_FRAME_BITS) - 1;
  localparam logic [7:0] AC_SYNC_BITS = 8'h10;

  typedef enum logic [1:0] {
    ROLE_SLAVE,
    ROLE_MASTER_EXT,
    ROLE_RESERVED,
    ROLE_MASTER
  } role_t;

endpackage : audio_cfg_pkg

// [hdl/audio_serial_config_control.sv]
// configuration, pin direction and framing control of the audio link
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
module audio_serial_config_control (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // avalon-mm slave
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // fifo levels from the data path
  input wire logic [audio_cfg_pkg::LEVEL_W-1:0] RX_LEVEL_I,
  input wire logic [audio_cfg_pkg::LEVEL_W-1:0] TX_LEVEL_I,
  output logic RX_SERVICE_O,
  output logic TX_SERVICE_O,
  // transmit sample feed
  input wire logic SAMPLE_REQ_I,
  input wire logic TX_VALID_I,
  input wire logic [audio_cfg_pkg::SAMPLE_W-1:0] TX_SAMPLE_I,
  output logic TX_TAKE_O,
  output logic [audio_cfg_pkg::SAMPLE_W-1:0] TX_OUT_SAMPLE_O,
  output logic UNDERFLOW_O,
  // serial data routing
  input wire logic SDATA_I,
  output logic RX_SDATA_O,
  output logic EXT_SDATA_O,
  input wire logic EXT_SDATA_I,
  output logic INT_SDATA_O,
  input wire logic INT_SDATA_I,
  // bit clock pin
  input wire logic BIT_CLK_I,
  output logic BIT_CLK_O,
  output logic BIT_CLK_OE_O,
  // sync pin
  input wire logic SYNC_I,
  output logic SYNC_O,
  output logic SYNC_OE_O,
  // status to the data path
  output logic ENABLE_O,
  output logic FORMAT_I2S_O,
  output logic CODEC_INTERNAL_O,
  output logic MASTER_O,
  output logic BIT_FALL_O,
  output logic FRAME_SYNC_O,
  output logic CTRL_RESET_O
);

  // ==========================================================
  // pin synchronisers
  logic bclk_s1_q, bclk_s2_q, bclk_s3_q;
  logic sync_s1_q, sync_s2_q;
  logic ext_s1_q, ext_s2_q;
  logic int_s1_q, int_s2_q;

  // logic reads the second stage, and the bit clock's third stage for falling-edge detection
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      int_s1_q <= 1'b0;
      int_s2_q <= 1'b0;
    end else begin
      bclk_s1_q <= BIT_CLK_I;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
      sync_s1_q <= SYNC_I;
      sync_s2_q <= sync_s1_q;
      ext_s1_q <= EXT_SDATA_I;
      ext_s2_q <= ext_s1_q;
      int_s1_q <= INT_SDATA_I;
      int_s2_q <= int_s1_q;
    end
  end

  // ==========================================================
  // bus slave
  logic ack_d, ack_q;
  logic [31:0] rdata_d, rdata_q;
  logic req;
  logic wr_go;
  logic [31:0] be_mask;
  logic [31:0] cfg_d, cfg_q;
  logic [31:0] fmt_d, fmt_q;
  logic [audio_cfg_pkg::DIV_W-1:0] div_d, div_q;
  logic srst_d, srst_q;
  logic rx_svc, tx_svc;

  assign req = AVS_READ_I || AVS_WRITE_I;
  // one wait state: request seen, then answered on the next cycle
  assign wr_go = AVS_WRITE_I && ack_q;
  assign be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                    {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

  always_comb begin
    ack_d = req && !ack_q;
    rdata_d = rdata_q;
    if (AVS_READ_I && !ack_q) begin
      unique case (AVS_ADDRESS_I)
        audio_cfg_pkg::OFS_CONFIG: begin
          rdata_d = cfg_q & audio_cfg_pkg::CONFIG_WMASK;
        end
        audio_cfg_pkg::OFS_FMT_CTRL: begin
          rdata_d = fmt_q;
        end
        audio_cfg_pkg::OFS_FIFO_STAT: begin
          rdata_d = '0;
          rdata_d[audio_cfg_pkg::STAT_RX_LVL_LSB +: audio_cfg_pkg::LEVEL_W]
            = RX_LEVEL_I;
          rdata_d[audio_cfg_pkg::STAT_TX_LVL_LSB +: audio_cfg_pkg::LEVEL_W]
            = TX_LEVEL_I;
          rdata_d[audio_cfg_pkg::STAT_RX_FLAG_BIT] = rx_svc;
          rdata_d[audio_cfg_pkg::STAT_TX_FLAG_BIT] = tx_svc;
        end
        audio_cfg_pkg::OFS_CLK_DIV: begin
          rdata_d = {28'h0000000, div_q};
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign AVS_WAITREQUEST_O = !ack_q;
  assign AVS_READDATA_O = rdata_q;

  // ==========================================================
  // configuration, format control and divider registers
  always_comb begin
    cfg_d = cfg_q;
    div_d = div_q;
    fmt_d = fmt_q;
    srst_d = 1'b0;
    if (wr_go && AVS_ADDRESS_I == audio_cfg_pkg::OFS_CONFIG) begin
      cfg_d = ((cfg_q & ~be_mask) | (AVS_WRITEDATA_I & be_mask))
              & audio_cfg_pkg::CONFIG_WMASK;
      srst_d = AVS_WRITEDATA_I[audio_cfg_pkg::RESET_BIT]
               && AVS_BYTEENABLE_I[0];
    end
    if (wr_go && AVS_ADDRESS_I == audio_cfg_pkg::OFS_CLK_DIV
        && AVS_BYTEENABLE_I[0]) begin
      div_d = AVS_WRITEDATA_I[audio_cfg_pkg::DIV_W-1:0];
    end
    if (srst_q) begin
      fmt_d = audio_cfg_pkg::FMT_RESET;
    end else if (wr_go && AVS_ADDRESS_I == audio_cfg_pkg::OFS_FMT_CTRL) begin
      fmt_d = ((fmt_q & ~be_mask) | (AVS_WRITEDATA_I & be_mask))
              & audio_cfg_pkg::FMT_WMASK;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      cfg_q <= audio_cfg_pkg::CONFIG_RESET;
      fmt_q <= audio_cfg_pkg::FMT_RESET;
      div_q <= audio_cfg_pkg::DIV_RESET;
      srst_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      fmt_q <= fmt_d;
      div_q <= div_d;
      srst_q <= srst_d;
    end
  end

  // ==========================================================
  // decoded settings
  logic enable, fmt_i2s, codec_int, clk_dir, sync_dir, policy, bclk_stop;
  audio_cfg_pkg::role_t role;

  assign enable = cfg_q[audio_cfg_pkg::ENABLE_BIT];
  assign fmt_i2s = cfg_q[audio_cfg_pkg::FORMAT_BIT];
  assign codec_int = cfg_q[audio_cfg_pkg::CODEC_BIT];
  assign clk_dir = cfg_q[audio_cfg_pkg::CLKDIR_BIT];
  assign sync_dir = cfg_q[audio_cfg_pkg::SYNCDIR_BIT];
  assign policy = cfg_q[audio_cfg_pkg::POLICY_BIT];
  assign bclk_stop = fmt_q[audio_cfg_pkg::STOP_BIT];

  always_comb begin
    unique case ({clk_dir, sync_dir})
      2'b00: role = audio_cfg_pkg::ROLE_SLAVE;
      2'b01: role = audio_cfg_pkg::ROLE_MASTER_EXT;
      2'b10: role = audio_cfg_pkg::ROLE_RESERVED;
      2'b11: role = audio_cfg_pkg::ROLE_MASTER;
    endcase
  end

  // ==========================================================
  // internal bit clock
  logic bclk_run, tick;
  logic bclk_d, bclk_q;

  // the reserved role drives the pin but keeps it low
  // settings are sampled live; changing them with the clock
  // running may glitch the pins, hence the stop control
  assign bclk_run = enable && fmt_i2s && role == audio_cfg_pkg::ROLE_MASTER
                    && !bclk_stop && !srst_q;

  bit_clock_divider u_div (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESET_N_I),
    .run_i(bclk_run),
    .div_i(div_q),
    .tick_o(tick)
  );

  always_comb begin
    bclk_d = 1'b0;
    if (bclk_run) begin
      bclk_d = bclk_q ^ tick;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      bclk_q <= 1'b0;
    end else begin
      bclk_q <= bclk_d;
    end
  end

  // ==========================================================
  // bit counting and frame sync
  logic int_clk, bit_fall;
  logic sync_out_en;
  logic [audio_cfg_pkg::BIT_CNT_W-1:0] cnt_d, cnt_q;
  logic sync_d, sync_q;
  logic fall_d, fall_q;

  assign int_clk = fmt_i2s && clk_dir;
  assign sync_out_en = !fmt_i2s || sync_dir;
  assign bit_fall = int_clk ? (tick && bclk_q)
                            : (bclk_s3_q && !bclk_s2_q);

  always_comb begin
    cnt_d = cnt_q;
    sync_d = sync_q;
    fall_d = 1'b0;
    if (!enable || srst_q || role == audio_cfg_pkg::ROLE_RESERVED
        && fmt_i2s) begin
      cnt_d = '0;
      sync_d = 1'b0;
    end else if (bit_fall) begin
      fall_d = 1'b1;
      cnt_d = cnt_q + 1'b1;
      if (fmt_i2s) begin
        sync_d = cnt_d[audio_cfg_pkg::I2S_LR_BIT];
      end else begin
        sync_d = (cnt_d < audio_cfg_pkg::AC_SYNC_BITS);
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      cnt_q <= '0;
      sync_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sync_q <= sync_d;
      fall_q <= fall_d;
    end
  end

  // directions follow the settings even while disabled
  assign BIT_CLK_OE_O = int_clk;
  assign BIT_CLK_O = bclk_q;
  assign SYNC_OE_O = sync_out_en;
  assign SYNC_O = sync_out_en && sync_q;
  assign BIT_FALL_O = fall_q;
  assign FRAME_SYNC_O = sync_out_en ? sync_q : sync_s2_q;

  // ==========================================================
  // transmit sample and underflow policy
  logic [audio_cfg_pkg::SAMPLE_W-1:0] last_d, last_q;
  logic [audio_cfg_pkg::SAMPLE_W-1:0] out_d, out_q;
  logic unf_d, unf_q;
  logic req_ok;

  assign req_ok = SAMPLE_REQ_I && enable && !srst_q;
  assign TX_TAKE_O = req_ok && TX_VALID_I;

  always_comb begin
    last_d = last_q;
    out_d = out_q;
    unf_d = 1'b0;
    if (srst_q || !enable) begin
      last_d = '0;
      out_d = '0;
    end else if (req_ok) begin
      if (TX_VALID_I) begin
        last_d = TX_SAMPLE_I;
        out_d = TX_SAMPLE_I;
      end else begin
        unf_d = 1'b1;
        out_d = policy ? last_q : '0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      last_q <= '0;
      out_q <= '0;
      unf_q <= 1'b0;
    end else begin
      last_q <= last_d;
      out_q <= out_d;
      unf_q <= unf_d;
    end
  end

  assign TX_OUT_SAMPLE_O = out_q;
  assign UNDERFLOW_O = unf_q;

  // ==========================================================
  // codec routing
  logic ext_d, ext_q, int_d, int_q, rx_d, rx_q;

  always_comb begin
    ext_d = enable && !codec_int && SDATA_I;
    int_d = enable && codec_int && SDATA_I;
    rx_d = enable && (codec_int ? int_s2_q : ext_s2_q);
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      ext_q <= 1'b0;
      int_q <= 1'b0;
      rx_q <= 1'b0;
    end else begin
      ext_q <= ext_d;
      int_q <= int_d;
      rx_q <= rx_d;
    end
  end

  assign EXT_SDATA_O = ext_q;
  assign INT_SDATA_O = int_q;
  assign RX_SDATA_O = rx_q;

  // ==========================================================
  // service thresholds
  threshold_compare #(.IS_RX(1'b1)) u_rx_th (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESET_N_I),
    .field_i(cfg_q[audio_cfg_pkg::RX_TH_LSB +: audio_cfg_pkg::TH_W]),
    .level_i(RX_LEVEL_I),
    .service_o(rx_svc)
  );

  threshold_compare #(.IS_RX(1'b0)) u_tx_th (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESET_N_I),
    .field_i(cfg_q[audio_cfg_pkg::TX_TH_LSB +: audio_cfg_pkg::TH_W]),
    .level_i(TX_LEVEL_I),
    .service_o(tx_svc)
  );

  assign RX_SERVICE_O = rx_svc;
  assign TX_SERVICE_O = tx_svc;

  // ==========================================================
  // status outputs
  assign ENABLE_O = enable;
  assign FORMAT_I2S_O = fmt_i2s;
  assign CODEC_INTERNAL_O = codec_int;
  assign MASTER_O = fmt_i2s && (role == audio_cfg_pkg::ROLE_MASTER
                    || role == audio_cfg_pkg::ROLE_MASTER_EXT);
  assign CTRL_RESET_O = srst_q;

endmodule : audio_serial_config_control

// [hdl/bit_clock_divider.sv]
// divider giving one-cycle ticks for the internal bit clock
module bit_clock_divider (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic [audio_cfg_pkg::DIV_W-1:0] div_i,
  // tick every div_i + 1 cycles
  output logic tick_o
);

  logic [audio_cfg_pkg::DIV_W-1:0] cnt_d;
  logic [audio_cfg_pkg::DIV_W-1:0] cnt_q;

  // ==========================================================
  // counter
  always_comb begin
    cnt_d = '0;
    if (run_i && cnt_q != div_i) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick_o = run_i && (cnt_q == div_i);

endmodule : bit_clock_divider

// [hdl/threshold_compare.sv]
// fifo level against programmed threshold, one registered service flag
module threshold_compare #(
  parameter bit IS_RX = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // threshold and level
  input wire logic [audio_cfg_pkg::TH_W-1:0] field_i,
  input wire logic [audio_cfg_pkg::LEVEL_W-1:0] level_i,
  // flag
  output logic service_o
);

  logic [audio_cfg_pkg::LEVEL_W-1:0] sum;
  logic [audio_cfg_pkg::LEVEL_W-1:0] th;
  logic svc_d;
  logic svc_q;

  // ==========================================================
  // compare
  always_comb begin
    sum = {2'b00, field_i} + audio_cfg_pkg::LEVEL_W'(IS_RX);
    th = {sum[audio_cfg_pkg::LEVEL_W-2:0], 1'b0};
    if (IS_RX) begin
      svc_d = (level_i >= th);
    end else begin
      svc_d = (level_i <= th);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      svc_q <= 1'b0;
    end else begin
      svc_q <= svc_d;
    end
  end

  assign service_o = svc_q;

endmodule : threshold_compare

// [verif/audio_serial_config_control_assertions.sv]
// port checker of the audio serial configuration block
module audio_cfg_checker (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [5:0] RX_LEVEL_I,
  input wire logic [5:0] TX_LEVEL_I,
  input wire logic RX_SERVICE_O,
  input wire logic TX_SERVICE_O,
  input wire logic SAMPLE_REQ_I,
  input wire logic TX_VALID_I,
  input wire logic TX_TAKE_O,
  input wire logic [23:0] TX_OUT_SAMPLE_O,
  input wire logic UNDERFLOW_O,
  input wire logic BIT_CLK_O,
  input wire logic BIT_CLK_OE_O,
  input wire logic SYNC_OE_O,
  input wire logic ENABLE_O,
  input wire logic FORMAT_I2S_O,
  input wire logic CODEC_INTERNAL_O,
  input wire logic BIT_FALL_O,
  input wire logic CTRL_RESET_O
);
  logic [31:0] cfg_q, cfg_d, bm;
  logic acc, rx_hit, tx_hit;
  // ==========================================
  // mirror of the configuration register seen from the bus
  assign acc = !AVS_WAITREQUEST_O && (AVS_READ_I || AVS_WRITE_I);
  always_comb begin
    bm = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
          {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
    cfg_d = cfg_q;
    if (acc && AVS_WRITE_I && AVS_ADDRESS_I == 6'h00) begin
      cfg_d = ((cfg_q & ~bm) | (AVS_WRITEDATA_I & bm))
              & audio_cfg_pkg::CONFIG_WMASK;
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) cfg_q <= audio_cfg_pkg::CONFIG_RESET;
    else cfg_q <= cfg_d;
  end
  assign rx_hit = RX_LEVEL_I >= ({2'h0, cfg_q[15:12]} + 6'h01) * 6'h02;
  assign tx_hit = TX_LEVEL_I <= {1'h0, cfg_q[11:8], 1'h0};
  // ==========================================
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  sequence rst_req;
    acc && AVS_WRITE_I && AVS_ADDRESS_I == 6'h00 && AVS_WRITEDATA_I[3]
      && AVS_BYTEENABLE_I[0];
  endsequence
  sequence rst_pulse;
    CTRL_RESET_O ##1 !CTRL_RESET_O;
  endsequence
  one_wait_a: assert property ((AVS_READ_I || AVS_WRITE_I) &&
    AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("bus answer not one wait state");
  cfg_read_a: assert property (acc && AVS_READ_I &&
    AVS_ADDRESS_I == 6'h00 |-> AVS_READDATA_O == cfg_q)
    else $error("config read data wrong");
  rx_flag_a: assert property ($past(RESET_N_I) |->
    RX_SERVICE_O == $past(rx_hit)) else $error("rx flag wrong");
  tx_flag_a: assert property ($past(RESET_N_I) |->
    TX_SERVICE_O == $past(tx_hit)) else $error("tx flag wrong");
  zero_fill_a: assert property (SAMPLE_REQ_I && ENABLE_O &&
    !CTRL_RESET_O && !TX_VALID_I && !cfg_q[6]
    |=> UNDERFLOW_O && TX_OUT_SAMPLE_O == 24'h000000)
    else $error("underflow sample not zero");
  cfg_out_a: assert property (ENABLE_O == cfg_q[0] &&
    FORMAT_I2S_O == cfg_q[4] && CODEC_INTERNAL_O == cfg_q[5] &&
    TX_TAKE_O == (SAMPLE_REQ_I && cfg_q[0] && !CTRL_RESET_O && TX_VALID_I))
    else $error("config outputs wrong");
  soft_reset_a: assert property (rst_req |=> rst_pulse)
    else $error("soft reset pulse wrong");
  pin_dir_a: assert property (BIT_CLK_OE_O == (cfg_q[4] && cfg_q[2])
    && SYNC_OE_O == (!cfg_q[4] || cfg_q[1])) else $error("pin direction wrong");
  idle_low_a: assert property ((!ENABLE_O)[*4] |->
    !BIT_CLK_O && !BIT_FALL_O) else $error("disabled output not low");
endmodule : audio_cfg_checker

bind audio_serial_config_control audio_cfg_checker u_chk (.*);

// [verif/audio_serial_config_control_bench.sv]
// self-checking bench of the audio serial configuration block
module audio_serial_config_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS_I = 1'h0, RESET_N_I = 1'h0, AVS_READ_I = 1'h0;
  logic AVS_WRITE_I = 1'h0, SAMPLE_REQ_I = 1'h0, TX_VALID_I = 1'h0;
  logic SDATA_I = 1'h0, lvl = 1'h0, run = 1'h0;
  logic [5:0] AVS_ADDRESS_I = 6'h00, RX_LEVEL_I = 6'h00, TX_LEVEL_I = 6'h00;
  logic [31:0] AVS_WRITEDATA_I = 32'h0, AVS_READDATA_O, rd, cfg, last, s;
  logic [3:0] AVS_BYTEENABLE_I = 4'hf;
  logic [23:0] TX_SAMPLE_I = 24'h0, TX_OUT_SAMPLE_O;
  logic EXT_SDATA_I, INT_SDATA_I, BIT_CLK_I, SYNC_I, AVS_WAITREQUEST_O;
  logic RX_SERVICE_O, TX_SERVICE_O, TX_TAKE_O, UNDERFLOW_O, RX_SDATA_O;
  logic EXT_SDATA_O, INT_SDATA_O, BIT_CLK_O, BIT_CLK_OE_O, SYNC_O, SYNC_OE_O;
  logic ENABLE_O, FORMAT_I2S_O, CODEC_INTERNAL_O, MASTER_O, BIT_FALL_O;
  logic FRAME_SYNC_O, CTRL_RESET_O;
  int failures = 0, num_checks = 0, n, c;
  audio_serial_config_control u_dut (.*);
  codec_model u_codec (.clk_i(CLK_SYS_I), .run_i(run), .lvl_i(lvl),
    .bclk_o(BIT_CLK_I), .sync_o(SYNC_I), .ext_sd_o(EXT_SDATA_I),
    .int_sd_o(INT_SDATA_I));
  always #5 CLK_SYS_I = ~CLK_SYS_I;
  // ==========================================
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic we, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge CLK_SYS_I);
    AVS_READ_I <= !we;
    AVS_WRITE_I <= we;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    // only the watchdog ends a wait that never gets an answer
    do @(posedge CLK_SYS_I);
    while (AVS_WAITREQUEST_O !== 1'h0);
    rd = AVS_READDATA_O;
    AVS_READ_I <= 1'h0;
    AVS_WRITE_I <= 1'h0;
    if (we && a == 6'h00) cfg = d & audio_cfg_pkg::CONFIG_WMASK;
  endtask : bus
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK_SYS_I);
    #1;
  endtask : cyc
  // one whole high phase of frame sync: n bit falls over c cycles
  task automatic frame();
    for (c = 0; c < 3000 && FRAME_SYNC_O === 1'h1; c++) cyc(1);
    for (c = 0; c < 3000 && FRAME_SYNC_O === 1'h0; c++) cyc(1);
    n = 0;
    for (c = 0; c < 3000 && FRAME_SYNC_O === 1'h1; c++) begin
      cyc(1);
      n += BIT_FALL_O;
    end
  endtask : frame
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  // ==========================================
  initial begin
    s = 32'd96586;
    last = 32'h0;
    cfg = audio_cfg_pkg::CONFIG_RESET;
    repeat (2) @(posedge CLK_SYS_I);
    RESET_N_I <= 1'h1;
    rdchk(6'h00, 32'h00007800);
    rdchk(6'h10, 32'h0);
    rdchk(6'h30, 32'h3);
    bus(1'h1, 6'h3c, 32'hffffffff);
    rdchk(6'h3c, 32'h0);
    bus(1'h1, 6'h10, 32'h10);
    bus(1'h1, 6'h00, 32'hffffffff);
    rdchk(6'h00, 32'h0000ff77);
    rdchk(6'h10, 32'h0);
    bus(1'h1, 6'h10, 32'h10);
    // thresholds at a randomly chosen side of the edge for each field value
    for (int f = 0; f < 16; f++) begin
      bus(1'h1, 6'h00, f * 32'h1100);
      n = (f + 1) * 2 - (rnd() & 1);
      c = f * 2 + (rnd() & 1);
      @(posedge CLK_SYS_I);
      RX_LEVEL_I <= n[5:0];
      TX_LEVEL_I <= c[5:0];
      cyc(2);
      chk(RX_SERVICE_O, n >= (f + 1) * 2);
      chk(TX_SERVICE_O, c <= f * 2);
      rdchk(6'h14, (n << 24) | (c << 8) | (n >= (f + 1) * 2 ? 'h10 : 0)
            | (c <= f * 2 ? 'h8 : 0));
    end
    // sample feed with both underflow policies
    for (int p = 0; p < 2; p++) begin
      bus(1'h1, 6'h00, 32'h1 | (p << 6));
      for (int i = 0; i < 6; i++) begin
        n = (i < 2) ? i : rnd() & 1;
        @(posedge CLK_SYS_I);
        SAMPLE_REQ_I <= 1'h1;
        TX_VALID_I <= n[0];
        TX_SAMPLE_I <= rnd() & 24'hffffff;
        @(posedge CLK_SYS_I);
        SAMPLE_REQ_I <= 1'h0;
        if (n) last = TX_SAMPLE_I;
        #1;
        chk(UNDERFLOW_O, !n);
        chk(TX_OUT_SAMPLE_O, n ? last : (p ? last : 32'h0));
      end
    end
    // directions change only with the bit clock stopped
    bus(1'h1, 6'h10, 32'h10);
    for (int k = 0; k < 8; k++) begin
      bus(1'h1, 6'h00, (k[2] << 4) | (k[1] << 2) | (k[0] << 1));
      cyc(1);
      chk(BIT_CLK_OE_O, k[2] & k[1]);
      chk(SYNC_OE_O, !k[2] | k[0]);
      chk(FORMAT_I2S_O, k[2]);
      chk(MASTER_O, k[2] & k[0]);
    end
    bus(1'h1, 6'h00, 32'h16);
    bus(1'h1, 6'h10, 32'h0);
    bus(1'h1, 6'h00, 32'h17);
    cyc(1);
    frame();
    chk(n, 32);
    chk(c, 256);
    bus(1'h1, 6'h10, 32'h10);
    bus(1'h1, 6'h00, 32'h16);
    cyc(4);
    chk(BIT_CLK_O, 1'h0);
    chk(BIT_CLK_OE_O, 1'h1);
    chk(SYNC_O, 1'h0);
    chk(SYNC_OE_O, 1'h1);
    bus(1'h1, 6'h00, 32'h0);
    // routing to either codec, AC-link with a running codec clock
    run <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      bus(1'h1, 6'h00, 32'h1 | (k[1] << 5));
      lvl <= k[0];
      SDATA_I <= k[0];
      cyc(6);
      chk(CODEC_INTERNAL_O, k[1]);
      chk(RX_SDATA_O, k[1] ? k[0] : !k[0]);
      chk(k[1] ? INT_SDATA_O : EXT_SDATA_O, k[0]);
      chk(k[1] ? EXT_SDATA_O : INT_SDATA_O, 1'h0);
    end
    frame();
    chk(n, 16);
    chk(c, 96);
    run <= 1'h0;
    bus(1'h1, 6'h30, 32'h5);
    bus(1'h1, 6'h00, 32'h10);
    bus(1'h1, 6'h10, 32'h10);
    bus(1'h1, 6'h00, 32'h18);
    rdchk(6'h10, 32'h0);
    rdchk(6'h30, 32'h5);
    rdchk(6'h00, 32'h10);
    // a second reset in mid-run brings back the reset values
    @(posedge CLK_SYS_I);
    RESET_N_I <= 1'h0;
    repeat (2) @(posedge CLK_SYS_I);
    RESET_N_I <= 1'h1;
    rdchk(6'h30, 32'h3);
    rdchk(6'h00, 32'h00007800);
    wrap_up();
  end
endmodule : audio_serial_config_control_bench

// [verif/codec_model.sv]
// behavioural audio codec pair: bit clock, sync and serial data lines
module codec_model (
  // control from the bench
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic lvl_i,
  // codec pins
  output logic bclk_o,
  output logic sync_o,
  output logic ext_sd_o,
  output logic int_sd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q = 2'h0;
  logic [5:0] bits_q = 6'h00;
  // ==========================================
  // clocks stand still outside a run
  always @(posedge clk_i) begin
    if (run_i) begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2) begin
        bclk_o <= ~bclk_o;
        if (bclk_o) bits_q <= bits_q + 6'h01;
      end
    end
  end
  initial bclk_o = 1'h0;
  assign sync_o = bits_q[5];
  // the two codecs send opposite levels so a wrong route shows
  assign int_sd_o = lvl_i;
  assign ext_sd_o = ~lvl_i;
endmodule : codec_model
